// [hw/lbc_cfg.svh]
// Purpose: Register map, field positions, reset values and timing counts.
// Assumes: Included by its bare name.
// Notes:   Definitions only.
`ifndef LBC_CFG_SVH
`define LBC_CFG_SVH
// ==========================================================
// Register offsets
`define LBC_A_PORT0   8'h00
`define LBC_A_PORT4   8'h04
`define LBC_A_GRPALL  8'h0A
`define LBC_A_GRP01   8'h0B
`define LBC_A_GRP234  8'h0C
`define LBC_A_PORTIN  8'h0E
`define LBC_A_CFG     8'h10
`define LBC_A_RDN     8'h11
`define LBC_A_RUP     8'h12
`define LBC_A_CUR     8'h13
`define LBC_A_GCUR    8'h15
`define LBC_A_DHI     8'h20
`define LBC_A_DLO     8'h21
`define LBC_A_STAT    8'h22
// ==========================================================
// Reset values
`define LBC_R_PORT    8'hFF
`define LBC_R_CFG     8'h00
`define LBC_R_RAMP    8'h00
`define LBC_R_CUR     8'h03
`define LBC_R_GCUR    8'h07
`define LBC_R_DUTY    8'h00
`define LBC_R_STBY    1'b1
// ==========================================================
// Configuration fields
`define LBC_CF_HALF   7
`define LBC_CF_RSTPOR 6
`define LBC_CF_STAG   5
`define LBC_CF_HOLD   4
`define LBC_CF_FADE   3
`define LBC_CF_RUP    2
`define LBC_CF_RRUN   1
`define LBC_CF_RUN    0
`define LBC_CF_WMASK  8'hE3
// Status fields
`define LBC_SF_FLT    1
`define LBC_SF_STBY   0
// ==========================================================
// Timing
`define LBC_CLK_NS    25
`define LBC_TICK_NS   8000
`define LBC_TICK_CYC  (`LBC_TICK_NS / `LBC_CLK_NS)
`endif

// [hw/lbc_pkg.sv]
// Purpose: Types shared by the boost and configuration block.
// Assumes: Constants come from lbc_cfg.svh.
// Notes:   Nothing is imported elsewhere.
package lbc_pkg;
   // ==========================================================
   // Serial slave states, Gray along address, pointer, data.
   typedef enum logic [2:0] {
      LBC_IDLE  = 3'b000,
      LBC_ADDR  = 3'b001,
      LBC_ACK   = 3'b011,
      LBC_PTR   = 3'b010,
      LBC_WDATA = 3'b110,
      LBC_RDATA = 3'b111,
      LBC_RACK  = 3'b101
   } lbc_st_t;
   // Raw fault levels from the converter, order D4..D1.
   typedef struct packed {
      logic schottky_open;
      logic current_limit;
      logic thermal;
      logic overvoltage;
   } lbc_fault_t;
   // Control registers handed to port logic.
   typedef struct packed {
      logic [4:0][7:0] port_ctrl;
      logic [7:0]      ramp_down;
      logic [7:0]      ramp_up;
      logic [7:0]      cur_scale;
      logic [7:0]      glob_cur;
   } lbc_ctrl_t;
endpackage

// [hw/lbc_top.sv]
// Purpose: Configuration registers, boost enable PWM and boost status.
// Assumes: Two-wire serial pins and reset pin are asynchronous to mclk_in.
// Notes:   Port PWM, ramps and analog converter live elsewhere.
`timescale 1ns/10ps
`include "lbc_cfg.svh"
module lbc_top #(
   parameter logic [6:0] SLAVE_ADDR = 7'h40,
   parameter int         PWM_BITS   = 10,
   parameter int         TICK_CYC   = `LBC_TICK_CYC
) (
   input  wire logic               mclk_in,
   input  wire logic               resetn_in,
   input  wire logic               scl_in,
   input  wire logic               sda_in,
   input  wire logic               rst_pin_n_in,
   input  wire lbc_pkg::lbc_fault_t fault_in,
   input  wire logic               holdoff_in,
   input  wire logic               fade_in,
   input  wire logic               rampup_in,
   output logic                    sda_drv_out,
   output logic                    sda_oe_out,
   output lbc_pkg::lbc_ctrl_t      ctrl_out,
   output logic                    boost_half_out,
   output logic                    stagger_out,
   output logic                    run_out,
   output logic                    standby_out,
   output logic                    boost_en_out
);
   if (PWM_BITS != 10 || TICK_CYC < 8 || TICK_CYC > 511) begin : g_chk
      $error("lbc_top: unsupported PWM width or tick count");
   end
   // ==========================================================
   // Synchronisers and edge detection
   logic [1:0] scl_s_ff, sda_s_ff, rstp_s_ff;
   logic [3:0] flt_s1_ff, flt_s2_ff;
   logic       scl_d_ff, sda_d_ff, rstp_d_ff;
   always_ff @(posedge mclk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         scl_s_ff  <= 2'b11;
         sda_s_ff  <= 2'b11;
         rstp_s_ff <= 2'b11;
         flt_s1_ff <= 4'h0;
         flt_s2_ff <= 4'h0;
         scl_d_ff  <= 1'b1;
         sda_d_ff  <= 1'b1;
         rstp_d_ff <= 1'b1;
      end else begin
         scl_s_ff  <= {scl_s_ff[0], scl_in};
         sda_s_ff  <= {sda_s_ff[0], sda_in};
         rstp_s_ff <= {rstp_s_ff[0], rst_pin_n_in};
         flt_s1_ff <= fault_in;
         flt_s2_ff <= flt_s1_ff;
         scl_d_ff  <= scl_s_ff[1];
         sda_d_ff  <= sda_s_ff[1];
         rstp_d_ff <= rstp_s_ff[1];
      end
   end
   logic scl, sda, scl_rise, scl_fall, i2c_start, i2c_stop, pin_fall;
   assign scl       = scl_s_ff[1];
   assign sda       = sda_s_ff[1];
   assign scl_rise  = scl & ~scl_d_ff;
   assign scl_fall  = ~scl & scl_d_ff;
   assign i2c_start = scl & scl_d_ff & sda_d_ff & ~sda;
   assign i2c_stop  = scl & scl_d_ff & ~sda_d_ff & sda;
   assign pin_fall  = rstp_d_ff & ~rstp_s_ff[1];
   // ==========================================================
   // Register state
   logic [4:0][7:0] port_ff, nxt_port;
   logic [7:0] cfg_ff, nxt_cfg, rdn_ff, nxt_rdn, rup_ff, nxt_rup;
   logic [7:0] cur_ff, nxt_cur, gcur_ff, nxt_gcur, dhi_ff, nxt_dhi;
   logic [1:0] dlo_ff, nxt_dlo;
   logic [3:0] flt_ff, nxt_flt;
   logic       stby_ff, nxt_stby;
   // Pointer auto-increment follows the device address map.
   function automatic logic [7:0] next_ptr(input logic [7:0] a);
      case (a)
         8'h00, 8'h01, 8'h02, 8'h03: next_ptr = a + 8'h01;
         8'h04, 8'h0A, 8'h0B, 8'h0C, 8'h0D, `LBC_A_GCUR: next_ptr = `LBC_A_CFG;
         `LBC_A_CFG, `LBC_A_RDN, `LBC_A_RUP, `LBC_A_CUR, `LBC_A_DHI:
            next_ptr = a + 8'h01;
         default: next_ptr = a;
      endcase
   endfunction
   function automatic logic [7:0] rd_byte(input logic [7:0] a);
      case (a)
         8'h00, 8'h01, 8'h02, 8'h03, 8'h04: rd_byte = port_ff[a[2:0]];
         `LBC_A_GRPALL, `LBC_A_GRP01, `LBC_A_GRP234: rd_byte = port_ff[0];
         `LBC_A_CFG: rd_byte = {cfg_ff[7:5], holdoff_in, fade_in, rampup_in,
                                cfg_ff[1:0]};
         `LBC_A_RDN:  rd_byte = rdn_ff;
         `LBC_A_RUP:  rd_byte = rup_ff;
         `LBC_A_CUR:  rd_byte = cur_ff;
         `LBC_A_GCUR: rd_byte = gcur_ff;
         `LBC_A_DHI:  rd_byte = dhi_ff;
         `LBC_A_DLO:  rd_byte = {6'h00, dlo_ff};
         `LBC_A_STAT: rd_byte = {3'h0, flt_ff, stby_ff};
         default:     rd_byte = 8'h00;
      endcase
   endfunction
   // ==========================================================
   // Two-wire slave
   lbc_pkg::lbc_st_t st_ff, nxt_st, ackto_ff, nxt_ackto;
   logic [3:0] bit_ff, nxt_bit;
   logic [7:0] sh_ff, nxt_sh, ptr_ff, nxt_ptr;
   logic       oe_ff, nxt_oe, nack_ff, nxt_nack, wr_stb, rd_stb, load;
   assign load = scl_fall && ((st_ff == lbc_pkg::LBC_ACK && ackto_ff == lbc_pkg::LBC_RDATA)
                 || (st_ff == lbc_pkg::LBC_RACK && !nack_ff));
   always_comb begin
      nxt_st    = st_ff;
      nxt_ackto = ackto_ff;
      nxt_bit   = bit_ff;
      nxt_sh    = sh_ff;
      nxt_ptr   = ptr_ff;
      nxt_oe    = oe_ff;
      nxt_nack  = nack_ff;
      wr_stb    = 1'b0;
      rd_stb    = 1'b0;
      if (!rstp_s_ff[1] || i2c_stop) begin
         nxt_st = lbc_pkg::LBC_IDLE;
         nxt_oe = 1'b0;
      end else if (i2c_start) begin
         nxt_st  = lbc_pkg::LBC_ADDR;
         nxt_bit = 4'h0;
         nxt_oe  = 1'b0;
      end else if (load) begin
         nxt_sh  = rd_byte(ptr_ff);
         nxt_oe  = ~nxt_sh[7];
         nxt_ptr = next_ptr(ptr_ff);
         rd_stb  = 1'b1;
         nxt_bit = 4'h0;
         nxt_st  = lbc_pkg::LBC_RDATA;
      end else begin
         case (st_ff)
            lbc_pkg::LBC_ADDR, lbc_pkg::LBC_PTR, lbc_pkg::LBC_WDATA: begin
               if (scl_rise && bit_ff < 4'h8) begin
                  nxt_sh  = {sh_ff[6:0], sda};
                  nxt_bit = bit_ff + 4'h1;
               end else if (scl_fall && bit_ff == 4'h8) begin
                  nxt_bit = 4'h0;
                  nxt_oe  = 1'b1;
                  nxt_st  = lbc_pkg::LBC_ACK;
                  nxt_ackto = lbc_pkg::LBC_WDATA;
                  if (st_ff == lbc_pkg::LBC_ADDR) begin
                     nxt_ackto = sh_ff[0] ? lbc_pkg::LBC_RDATA : lbc_pkg::LBC_PTR;
                     if (sh_ff[7:1] != SLAVE_ADDR) begin
                        nxt_oe = 1'b0;
                        nxt_st = lbc_pkg::LBC_IDLE;
                     end
                  end else if (st_ff == lbc_pkg::LBC_PTR) begin
                     nxt_ptr = sh_ff;
                  end else begin
                     wr_stb  = 1'b1;
                     nxt_ptr = next_ptr(ptr_ff);
                  end
               end
            end
            lbc_pkg::LBC_ACK: begin
               if (scl_fall) begin
                  nxt_oe = 1'b0;
                  nxt_st = ackto_ff;
               end
            end
            lbc_pkg::LBC_RDATA: begin
               if (scl_rise) begin
                  nxt_bit = bit_ff + 4'h1;
               end else if (scl_fall && bit_ff == 4'h8) begin
                  nxt_oe  = 1'b0;
                  nxt_bit = 4'h0;
                  nxt_st  = lbc_pkg::LBC_RACK;
               end else if (scl_fall && bit_ff != 4'h0) begin
                  nxt_sh = {sh_ff[6:0], 1'b0};
                  nxt_oe = ~sh_ff[6];
               end
            end
            lbc_pkg::LBC_RACK: begin
               if (scl_rise) begin
                  nxt_nack = sda;
               end else if (scl_fall) begin
                  nxt_st = lbc_pkg::LBC_IDLE;
               end
            end
            default: nxt_st = lbc_pkg::LBC_IDLE;
         endcase
      end
   end
   always_ff @(posedge mclk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         st_ff    <= lbc_pkg::LBC_IDLE;
         ackto_ff <= lbc_pkg::LBC_IDLE;
         bit_ff   <= 4'h0;
         sh_ff    <= 8'h00;
         ptr_ff   <= 8'h00;
         oe_ff    <= 1'b0;
         nack_ff  <= 1'b0;
      end else begin
         st_ff    <= nxt_st;
         ackto_ff <= nxt_ackto;
         bit_ff   <= nxt_bit;
         sh_ff    <= nxt_sh;
         ptr_ff   <= nxt_ptr;
         oe_ff    <= nxt_oe;
         nack_ff  <= nxt_nack;
      end
   end
   // ==========================================================
   // Register writes, restore and fault flags
   logic restore, stat_rd;
   assign restore = pin_fall & cfg_ff[`LBC_CF_RSTPOR];
   assign stat_rd = rd_stb && ptr_ff == `LBC_A_STAT;
   always_comb begin
      nxt_port = port_ff;
      nxt_cfg  = cfg_ff;
      nxt_rdn  = rdn_ff;
      nxt_rup  = rup_ff;
      nxt_cur  = cur_ff;
      nxt_gcur = gcur_ff;
      nxt_dhi  = dhi_ff;
      nxt_dlo  = dlo_ff;
      nxt_stby = stby_ff;
      if (restore) begin
         nxt_port = {5{`LBC_R_PORT}};
         nxt_cfg  = `LBC_R_CFG;
         nxt_rdn  = `LBC_R_RAMP;
         nxt_rup  = `LBC_R_RAMP;
         nxt_cur  = `LBC_R_CUR;
         nxt_gcur = `LBC_R_GCUR;
         nxt_dhi  = `LBC_R_DUTY;
         nxt_dlo  = 2'b00;
         nxt_stby = `LBC_R_STBY;
      end else if (wr_stb) begin
         case (ptr_ff)
            8'h00, 8'h01, 8'h02, 8'h03, 8'h04: nxt_port[ptr_ff[2:0]] = sh_ff;
            `LBC_A_GRPALL: nxt_port = {5{sh_ff}};
            `LBC_A_GRP01:  nxt_port[1:0] = {2{sh_ff}};
            `LBC_A_GRP234: nxt_port[4:2] = {3{sh_ff}};
            `LBC_A_CFG:  nxt_cfg  = sh_ff & `LBC_CF_WMASK;
            `LBC_A_RDN:  nxt_rdn  = sh_ff;
            `LBC_A_RUP:  nxt_rup  = sh_ff;
            `LBC_A_CUR:  nxt_cur  = sh_ff;
            `LBC_A_GCUR: nxt_gcur = sh_ff;
            `LBC_A_DHI:  nxt_dhi  = sh_ff;
            `LBC_A_DLO:  nxt_dlo  = sh_ff[1:0];
            `LBC_A_STAT: nxt_stby = sh_ff[`LBC_SF_STBY];
            default: nxt_stby = stby_ff;
         endcase
      end
      // Reset-run brings the part out of shutdown on a pin pulse.
      if (pin_fall && cfg_ff[`LBC_CF_RRUN]) begin
         nxt_cfg[`LBC_CF_RUN] = 1'b1;
      end
      // Overheating forces standby and shutdown until software restarts.
      if (flt_s2_ff[1]) begin
         nxt_stby = 1'b1;
         nxt_cfg[`LBC_CF_RUN] = 1'b0;
      end
      // A fault present in the clearing cycle must not be lost.
      nxt_flt = (stat_rd ? 4'h0 : flt_ff) | flt_s2_ff;
   end
   always_ff @(posedge mclk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         port_ff <= {5{`LBC_R_PORT}};
         cfg_ff  <= `LBC_R_CFG;
         rdn_ff  <= `LBC_R_RAMP;
         rup_ff  <= `LBC_R_RAMP;
         cur_ff  <= `LBC_R_CUR;
         gcur_ff <= `LBC_R_GCUR;
         dhi_ff  <= `LBC_R_DUTY;
         dlo_ff  <= 2'b00;
         stby_ff <= `LBC_R_STBY;
         flt_ff  <= 4'h0;
      end else begin
         port_ff <= nxt_port;
         cfg_ff  <= nxt_cfg;
         rdn_ff  <= nxt_rdn;
         rup_ff  <= nxt_rup;
         cur_ff  <= nxt_cur;
         gcur_ff <= nxt_gcur;
         dhi_ff  <= nxt_dhi;
         dlo_ff  <= nxt_dlo;
         stby_ff <= nxt_stby;
         flt_ff  <= nxt_flt;
      end
   end
   // ==========================================================
   // Boost enable PWM
   logic [8:0]          tdiv_ff, nxt_tdiv;
   logic                tick_ff, nxt_tick, en_ff, nxt_en, sb_ff, nxt_sb;
   logic [PWM_BITS-1:0] cnt_ff, nxt_cnt, lat_ff, nxt_lat, duty;
   assign duty = {dhi_ff, dlo_ff};
   always_comb begin
      nxt_tick = tdiv_ff == 9'(TICK_CYC - 1);
      nxt_tdiv = nxt_tick ? 9'h000 : tdiv_ff + 9'h001;
      nxt_cnt  = cnt_ff;
      nxt_lat  = lat_ff;
      if (tick_ff) begin
         nxt_cnt = cnt_ff + 1'b1;
         // Duty changes only at a period boundary to avoid runt pulses.
         if (&cnt_ff) begin
            nxt_lat = duty;
         end
      end
      nxt_en = cfg_ff[`LBC_CF_RUN] & ~stby_ff & (cnt_ff < lat_ff);
      nxt_sb = stby_ff | (duty == '0);
   end
   always_ff @(posedge mclk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         tdiv_ff <= 9'h000;
         tick_ff <= 1'b0;
         cnt_ff  <= '0;
         lat_ff  <= '0;
         en_ff   <= 1'b0;
         sb_ff   <= 1'b1;
      end else begin
         tdiv_ff <= nxt_tdiv;
         tick_ff <= nxt_tick;
         cnt_ff  <= nxt_cnt;
         lat_ff  <= nxt_lat;
         en_ff   <= nxt_en;
         sb_ff   <= nxt_sb;
      end
   end
   // ==========================================================
   // Outputs
   assign sda_drv_out    = 1'b0;
   assign sda_oe_out     = oe_ff;
   assign ctrl_out       = {port_ff, rdn_ff, rup_ff, cur_ff, gcur_ff};
   assign boost_half_out = cfg_ff[`LBC_CF_HALF];
   assign stagger_out    = cfg_ff[`LBC_CF_STAG];
   assign run_out        = cfg_ff[`LBC_CF_RUN];
   assign standby_out    = sb_ff;
   assign boost_en_out   = en_ff;
   // ==========================================================
   // Checks
   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (!resetn_in);
   sequence s_stat_read;
      stat_rd ##0 (flt_s2_ff == 4'h0);
   endsequence
   sequence s_restore;
      restore ##1 1'b1;
   endsequence
   a_por_shutdown: assert property ($rose(resetn_in) |-> cfg_ff == 8'h00 && stby_ff)
      else $error("not in shutdown after reset");
   a_standby_off: assert property (stby_ff |=> !boost_en_out)
      else $error("boost enabled in standby");
   a_shutdown_off: assert property (!cfg_ff[0] |=> !boost_en_out)
      else $error("boost enabled in shutdown");
   a_duty_zero: assert property (lat_ff == '0 |=> !boost_en_out)
      else $error("boost enabled at zero duty");
   a_pwm_wrap: assert property (tick_ff && (&cnt_ff)
      |=> cnt_ff == '0 && lat_ff == $past(duty))
      else $error("period wrap or duty latch wrong");
   a_tick_gap: assert property (tick_ff |=> (!tick_ff)[*7])
      else $error("tick spacing too short");
   a_fault_sticky: assert property ((|flt_s2_ff)
      |=> (flt_ff & $past(flt_s2_ff)) == $past(flt_s2_ff))
      else $error("present fault not latched");
   a_read_clear: assert property (s_stat_read |=> flt_ff == 4'h0)
      else $error("status read did not clear faults");
   a_restore_ports: assert property (s_restore
      |-> port_ff == {5{8'hFF}} && cfg_ff[6:5] == 2'b00)
      else $error("reset pin did not restore defaults");
   a_cfg_ro_bits: assert property (wr_stb && ptr_ff == `LBC_A_CFG
      |=> cfg_ff[4:2] == 3'b000)
      else $error("read-only config bits stored");
   a_high_write: assert property (wr_stb && ptr_ff == `LBC_A_DHI && !restore
      |=> dhi_ff == $past(sh_ff) && dlo_ff == $past(dlo_ff))
      else $error("upper duty write wrong");
   a_zero_standby: assert property (duty == '0 |=> standby_out)
      else $error("zero duty not in standby");
endmodule // lbc_top

// [bench/lbc_host_model.sv]
// Purpose: Two-wire host that writes and reads the block's registers.
// Assumes: The data line is pulled up; each party only pulls it low.
// Notes:   One bit takes 8 mclk cycles (200 ns); clock stays high between frames.
`timescale 1ns/10ps
module lbc_host_model #(
   parameter logic [6:0] DEV_ADDR = 7'h40
) (
   input  wire logic mclk_in,
   input  wire logic sda_line_in,
   output logic      scl_out,
   output logic      sda_pull_out
);
   // ==========================================================
   // Bus primitives
   initial begin
      scl_out      = 1'b1;
      sda_pull_out = 1'b0;
   end
   task automatic wt(input int n);
      repeat (n) @(posedge mclk_in);
   endtask
   // Data moves two cycles after the clock falls, so the block never sees it
   // change while the clock is high and mistakes it for a start or stop.
   task automatic put_bit(input logic b, output logic seen);
      sda_pull_out <= ~b;
      wt(2);
      scl_out <= 1'b1;
      wt(2);
      seen = sda_line_in;
      wt(2);
      scl_out <= 1'b0;
      wt(2);
   endtask
   task automatic start();
      sda_pull_out <= 1'b0;
      wt(3);
      scl_out <= 1'b1;
      wt(3);
      sda_pull_out <= 1'b1;
      wt(3);
      scl_out <= 1'b0;
      wt(3);
   endtask
   task automatic stop();
      sda_pull_out <= 1'b1;
      wt(3);
      scl_out <= 1'b1;
      wt(3);
      sda_pull_out <= 1'b0;
      wt(3);
   endtask
   task automatic xfer(input logic [7:0] tx, input logic ack_bit, output logic [7:0] rx,
                       output logic ack);
      for (int i = 7; i >= 0; i--) begin
         put_bit(tx[i], rx[i]);
      end
      put_bit(ack_bit, ack);
   endtask
   // ==========================================================
   // Register access
   task automatic write_reg(input logic [7:0] ptr, input logic [7:0] data, output logic nak);
      logic [7:0] rx;
      logic       a0;
      logic       a1;
      logic       a2;
      start();
      xfer({DEV_ADDR, 1'b0}, 1'b1, rx, a0);
      xfer(ptr, 1'b1, rx, a1);
      xfer(data, 1'b1, rx, a2);
      stop();
      nak = a0 | a1 | a2;
   endtask
   task automatic read_reg(input logic [7:0] ptr, output logic [7:0] data, output logic nak);
      logic [7:0] rx;
      logic       a0;
      logic       a1;
      logic       a2;
      logic       a3;
      start();
      xfer({DEV_ADDR, 1'b0}, 1'b1, rx, a0);
      xfer(ptr, 1'b1, rx, a1);
      start();
      xfer({DEV_ADDR, 1'b1}, 1'b1, rx, a2);
      xfer(8'hff, 1'b1, data, a3);
      stop();
      nak = a0 | a1 | a2;
   endtask
endmodule // lbc_host_model

// [bench/tb_top.sv]
// Purpose: Self-checking bench for the boost PWM and configuration block.
// Assumes: A short tick of 8 cycles keeps one PWM period at 8192 cycles.
// Notes:   Registers are reached only through the two-wire host model.
`timescale 1ns/10ps
module tb_top;
   localparam int TICK = 8;
   localparam int PER  = 1024 * TICK;
   logic                mclk = 1'b0;
   logic                resetn;
   logic                rst_pin_n;
   logic                scl;
   logic                sda_pull;
   logic                sda_line;
   lbc_pkg::lbc_fault_t fault;
   logic                holdoff;
   logic                fade;
   logic                rampup;
   logic                sda_oe;
   lbc_pkg::lbc_ctrl_t  ctrl;
   logic                boost_half;
   logic                stagger;
   logic                run;
   logic                standby;
   logic                boost_en;
   int                  err_count = 0;
   int                  tests_run = 0;
   logic [15:0]         rmap [13] = '{16'h00ff, 16'h01ff, 16'h02ff, 16'h03ff, 16'h04ff,
                                      16'h1000, 16'h1100, 16'h1200, 16'h1303, 16'h1507,
                                      16'h2000, 16'h2100, 16'h2201};
   always #12.5 mclk = ~mclk;
   assign sda_line = ~(sda_pull | sda_oe);
   lbc_top #(.TICK_CYC(TICK)) dut (
      .mclk_in(mclk), .resetn_in(resetn), .scl_in(scl), .sda_in(sda_line),
      .rst_pin_n_in(rst_pin_n), .fault_in(fault), .holdoff_in(holdoff), .fade_in(fade),
      .rampup_in(rampup), .sda_drv_out(), .sda_oe_out(sda_oe), .ctrl_out(ctrl),
      .boost_half_out(boost_half), .stagger_out(stagger), .run_out(run),
      .standby_out(standby), .boost_en_out(boost_en));
   lbc_host_model host (
      .mclk_in(mclk), .sda_line_in(sda_line), .scl_out(scl), .sda_pull_out(sda_pull));
   // ==========================================================
   // Shared tasks
   task automatic report_and_stop();
      if (err_count == 0 && tests_run > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   task automatic check(input logic [71:0] seen, input logic [71:0] exp);
      tests_run++;
      if (seen !== exp) begin
         err_count++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [7:0] ptr, input logic [7:0] d);
      logic nak;
      host.write_reg(ptr, d, nak);
   endtask
   task automatic rd_chk(input logic [7:0] ptr, input logic [7:0] exp);
      logic [7:0] v;
      logic       nak;
      host.read_reg(ptr, v, nak);
      check(72'(nak), 72'h0);
      check(72'(v), 72'(exp));
   endtask
   // Counts enable cycles over one whole period after a settling period.
   task automatic measure(input int exp);
      logic [31:0] cnt;
      repeat (PER + 16) @(posedge mclk);
      cnt = 0;
      repeat (PER) begin
         @(negedge mclk);
         cnt = cnt + boost_en;
      end
      check(72'(cnt), 72'(exp));
   endtask
   task automatic pin_pulse();
      rst_pin_n <= 1'b0;
      repeat (10) @(posedge mclk);
      rst_pin_n <= 1'b1;
      repeat (10) @(posedge mclk);
   endtask
   task automatic fault_wait(input logic [3:0] f);
      fault <= f;
      repeat (10) @(posedge mclk);
   endtask
   // ==========================================================
   // Watchdog and main sequence
   initial begin
      repeat (99000) @(posedge mclk);
      err_count++;
      report_and_stop();
   end
   initial begin
      resetn    <= 1'b0;
      rst_pin_n <= 1'b1;
      fault     <= '0;
      holdoff   <= 1'b0;
      fade      <= 1'b0;
      rampup    <= 1'b0;
      repeat (4) @(posedge mclk);
      resetn <= 1'b1;
      repeat (4) @(posedge mclk);
      @(negedge mclk);
      check(ctrl, {{5{8'hff}}, 8'h00, 8'h00, 8'h03, 8'h07});
      check(72'({run, standby, boost_en}), 72'h2);
      for (int i = 0; i < 13; i++) begin
         rd_chk(rmap[i][15:8], rmap[i][7:0]);
      end
      holdoff <= 1'b1;
      rampup  <= 1'b1;
      wr(8'h10, 8'hff);
      rd_chk(8'h10, 8'hf7);
      check(72'({boost_half, stagger, run}), 72'h7);
      holdoff <= 1'b0;
      rampup  <= 1'b0;
      fade    <= 1'b1;
      wr(8'h10, 8'h01);
      rd_chk(8'h10, 8'h09);
      check(72'({boost_half, stagger}), 72'h0);
      fade <= 1'b0;
      wr(8'h21, 8'hff);
      rd_chk(8'h21, 8'h03);
      wr(8'h20, 8'h80);
      wr(8'h22, 8'h00);
      check(72'(standby), 72'h0);
      measure(515 * TICK);
      wr(8'h20, 8'hff);
      measure(1023 * TICK);
      wr(8'h10, 8'h00);
      measure(0);
      wr(8'h22, 8'h01);
      check(72'(standby), 72'h1);
      wr(8'h20, 8'h00);
      wr(8'h21, 8'h00);
      wr(8'h22, 8'h00);
      check(72'(standby), 72'h1);
      fault_wait(4'b0001);
      fault_wait(4'b0000);
      rd_chk(8'h22, 8'h02);
      rd_chk(8'h22, 8'h00);
      fault_wait(4'b0100);
      rd_chk(8'h22, 8'h08);
      rd_chk(8'h22, 8'h08);
      fault_wait(4'b0000);
      rd_chk(8'h22, 8'h08);
      rd_chk(8'h22, 8'h00);
      fault_wait(4'b1000);
      fault_wait(4'b0000);
      wr(8'h22, 8'hfe);
      rd_chk(8'h22, 8'h10);
      rd_chk(8'h22, 8'h00);
      fault_wait(4'b0010);
      fault_wait(4'b0000);
      rd_chk(8'h22, 8'h05);
      wr(8'h00, 8'h12);
      pin_pulse();
      rd_chk(8'h00, 8'h12);
      wr(8'h10, 8'h42);
      pin_pulse();
      rd_chk(8'h00, 8'hff);
      rd_chk(8'h10, 8'h01);
      report_and_stop();
   end
endmodule // tb_top
